// *** hw/pcl_load_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcl_load_seq
  import pcl_pkg::*;
#(
  parameter int unsigned POR_FAST_CYCLES = POR_FAST_CYC,
  parameter int unsigned POR_STD_CYCLES = POR_STD_CYC,
  parameter int unsigned STATUS_MIN_CYCLES = STATUS_MIN_CYC,
  parameter int unsigned INIT_MIN_CYCLES = INIT_MIN_CYC,
  parameter int unsigned UINIT_CYCLES = UINIT_EDGES
) (
  input wire logic sys_clk, // system clock, 250 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic config_request_n, // request pin, low restarts loading
  input wire logic config_clock, // configuration clock pin
  input wire logic [15:0] config_data, // parallel data pins
  input wire logic [1:0] scheme_select_pins, // strap pins
  input wire logic user_init_clock, // optional initialization clock pin
  input wire logic config_status_n_in, // status pin level
  output logic config_status_n_out, // status pin drive value
  output logic config_status_n_oe_n, // status pin enable, low drives
  output logic config_complete, // completion line
  output logic user_mode, // device has entered user mode
  output logic [15:0] cfg_word, // captured data item
  output logic cfg_word_valid, // one-cycle strobe per data item
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata // read data, cycle after strobe
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic req_s;
  logic clk_s;
  logic uclk_s;
  logic status_s;
  logic [15:0] data_s;
  logic [1:0] sel_s;

  pcl_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_req (
    .sys_clk(sys_clk), .srst(srst), .async_in(config_request_n), .sync_out(req_s));
  pcl_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_clk (
    .sys_clk(sys_clk), .srst(srst), .async_in(config_clock), .sync_out(clk_s));
  pcl_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_uclk (
    .sys_clk(sys_clk), .srst(srst), .async_in(user_init_clock), .sync_out(uclk_s));
  pcl_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_stat (
    .sys_clk(sys_clk), .srst(srst), .async_in(config_status_n_in), .sync_out(status_s));
  pcl_sync #(.WIDTH(16), .RESET_VAL(16'h0000)) u_sync_data (
    .sys_clk(sys_clk), .srst(srst), .async_in(config_data), .sync_out(data_s));
  pcl_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_sel (
    .sys_clk(sys_clk), .srst(srst), .async_in(scheme_select_pins), .sync_out(sel_s));

  // ****************************************************************
  // state
  // ****************************************************************
  pcl_state_t state_reg, state_next;
  logic clk_d_reg, clk_d_next;
  logic uclk_d_reg, uclk_d_next;
  logic [15:0] data_d_reg, data_d_next;
  logic [1:0] arm_reg, arm_next;
  logic por_fast_reg, por_fast_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [31:0] len_reg, len_next;
  logic [31:0] word_cnt_reg, word_cnt_next;
  logic [2:0] phase_reg, phase_next;
  logic [2:0] ratio_reg, ratio_next;
  logic status_oe_n_next;
  logic complete_next;
  logic user_next;
  logic [15:0] word_next;
  logic valid_next;
  logic [31:0] rdata_next;
  logic [2:0] ratio_sel;
  logic [2:0] phase_inc;
  logic clk_rise;
  logic uclk_rise;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_en;
  logic tmr_done;

  pcl_timer u_timer (
    .sys_clk(sys_clk), .srst(srst), .load(tmr_load), .load_val(tmr_val), .en(tmr_en), .done(tmr_done));

  // edges of the sampled clocks; data one stage older still sits before the edge
  assign clk_rise = clk_s & ~clk_d_reg;
  assign uclk_rise = uclk_s & ~uclk_d_reg;
  assign phase_inc = phase_reg + 3'h1;

  // ratio chosen from bus width, encryption and compression
  always_comb begin
    if (ctrl_reg[CTRL_W16_BIT]) begin
      if (ctrl_reg[CTRL_CMP_BIT]) begin
        ratio_sel = RATIO_4;
      end else if (ctrl_reg[CTRL_ENC_BIT]) begin
        ratio_sel = RATIO_2;
      end else begin
        ratio_sel = RATIO_1;
      end
    end else begin
      ratio_sel = ctrl_reg[CTRL_CMP_BIT] ? RATIO_2 : RATIO_1;
    end
  end

  // ****************************************************************
  // sequencer next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    arm_next = arm_reg;
    por_fast_next = por_fast_reg;
    word_cnt_next = word_cnt_reg;
    phase_next = phase_reg;
    ratio_next = ratio_reg;
    word_next = cfg_word;
    valid_next = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    tmr_en = 1'b1;
    case (state_reg)
      ST_POR: begin
        // reload while the strap settles, then let the delay run
        if (arm_reg != 2'h3) begin
          arm_next = arm_reg + 2'h1;
          por_fast_next = sel_s[SEL_FAST_BIT];
          tmr_load = 1'b1;
          tmr_val = sel_s[SEL_FAST_BIT] ? TMR_W'(POR_FAST_CYCLES) : TMR_W'(POR_STD_CYCLES);
        end else if (tmr_done) begin
          state_next = ST_RESET;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(STATUS_MIN_CYCLES);
        end
      end
      ST_RESET: begin
        // release once the request is back high and the least low time is over
        if (req_s && tmr_done) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // an outside agent may still hold the status line low
        if (status_s) begin
          state_next = ST_LOAD;
          word_cnt_next = '0;
          phase_next = '0;
          ratio_next = ratio_sel;
        end
      end
      ST_LOAD: begin
        if (clk_rise) begin
          phase_next = (phase_inc == ratio_reg) ? 3'h0 : phase_inc;
          if (phase_reg == 3'h0) begin
            word_next = ctrl_reg[CTRL_W16_BIT] ? data_d_reg : {8'h00, data_d_reg[7:0]};
            valid_next = 1'b1;
            word_cnt_next = word_cnt_reg + 32'h1;
            if (word_cnt_reg + 32'h1 >= len_reg) begin
              if (ratio_reg == RATIO_1) begin
                state_next = ST_INIT;
                tmr_load = 1'b1;
                tmr_val = ctrl_reg[CTRL_UCLK_BIT] ? TMR_W'(UINIT_CYCLES) : TMR_W'(INIT_MIN_CYCLES);
              end else begin
                state_next = ST_RUNOUT;
              end
            end
          end
        end
      end
      ST_RUNOUT: begin
        // the remaining edges finish decryption and decompression
        if (clk_rise) begin
          phase_next = phase_inc;
          if (phase_inc == ratio_reg) begin
            state_next = ST_INIT;
            phase_next = '0;
            tmr_load = 1'b1;
            tmr_val = ctrl_reg[CTRL_UCLK_BIT] ? TMR_W'(UINIT_CYCLES) : TMR_W'(INIT_MIN_CYCLES);
          end
        end
      end
      ST_INIT: begin
        // user clock counts its own edges, otherwise the timer counts cycles
        tmr_en = ctrl_reg[CTRL_UCLK_BIT] ? uclk_rise : 1'b1;
        if (tmr_done) begin
          state_next = ST_USER;
        end
      end
      ST_USER: begin
        state_next = ST_USER;
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
    // a request low restarts from any phase after power-on
    if (!req_s && state_reg != ST_POR && state_reg != ST_RESET) begin
      state_next = ST_RESET;
      tmr_load = 1'b1;
      tmr_val = TMR_W'(STATUS_MIN_CYCLES);
    end
    if (srst) begin
      state_next = ST_POR;
      arm_next = 2'h0;
      por_fast_next = 1'b0;
      word_cnt_next = '0;
      phase_next = '0;
      ratio_next = RATIO_1;
      word_next = '0;
      valid_next = 1'b0;
    end
  end

  // pin outputs follow the next state so they move with it
  always_comb begin
    status_oe_n_next = ~(state_next == ST_POR || state_next == ST_RESET);
    complete_next = (state_next == ST_INIT || state_next == ST_USER);
    user_next = (state_next == ST_USER);
    clk_d_next = srst ? 1'b0 : clk_s;
    uclk_d_next = srst ? 1'b0 : uclk_s;
    data_d_next = srst ? 16'h0000 : data_s;
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    len_next = len_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_next = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == REG_LEN) begin
      len_next = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_next = {28'h0, ctrl_reg};
        REG_LEN: rdata_next = len_reg;
        REG_STAT: begin
          rdata_next[STAT_STATE_LSB +: 3] = state_reg;
          rdata_next[STAT_RATIO_LSB +: 3] = ratio_reg;
          rdata_next[STAT_DONE_BIT] = config_complete;
          rdata_next[STAT_USER_BIT] = user_mode;
          rdata_next[STAT_FAST_BIT] = por_fast_reg;
        end
        REG_COUNT: rdata_next = word_cnt_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (srst) begin
      ctrl_next = CTRL_RESET;
      len_next = LEN_RESET;
      rdata_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
    arm_reg <= arm_next;
    por_fast_reg <= por_fast_next;
    word_cnt_reg <= word_cnt_next;
    phase_reg <= phase_next;
    ratio_reg <= ratio_next;
    cfg_word <= word_next;
    cfg_word_valid <= valid_next;
    config_status_n_oe_n <= status_oe_n_next;
    config_status_n_out <= 1'b0;
    config_complete <= complete_next;
    user_mode <= user_next;
    clk_d_reg <= clk_d_next;
    uclk_d_reg <= uclk_d_next;
    data_d_reg <= data_d_next;
    ctrl_reg <= ctrl_next;
    len_reg <= len_next;
    reg_rdata <= rdata_next;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [31:0] low_cnt_reg;
  logic [31:0] rel_cnt_reg;
  logic [31:0] init_cnt_reg;
  logic [31:0] uedge_cnt_reg;
  logic [31:0] por_cnt_reg;

  // counters seen only by the checks below
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_cnt_reg <= '0;
      rel_cnt_reg <= '0;
      init_cnt_reg <= '0;
      uedge_cnt_reg <= '0;
      por_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= config_status_n_oe_n ? 32'h0 : low_cnt_reg + 32'h1;
      rel_cnt_reg <= (state_reg == ST_RESET && req_s) ? rel_cnt_reg + 32'h1 : 32'h0;
      init_cnt_reg <= (config_complete && !user_mode) ? init_cnt_reg + 32'h1 : 32'h0;
      uedge_cnt_reg <= (state_reg != ST_INIT) ? 32'h0 : uedge_cnt_reg + {31'h0, uclk_rise};
      por_cnt_reg <= (state_reg == ST_POR) ? por_cnt_reg + 32'h1 : por_cnt_reg;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ratio_narrow_a: assert property ((state_reg == ST_LOAD && !ctrl_reg[CTRL_W16_BIT]) |->
    ratio_reg == (ctrl_reg[CTRL_CMP_BIT] ? RATIO_2 : RATIO_1)) else $error("narrow bus ratio wrong");
  ratio_wide_a: assert property ((state_reg == ST_LOAD && ctrl_reg[CTRL_W16_BIT]) |->
    ratio_reg == (ctrl_reg[CTRL_CMP_BIT] ? RATIO_4 : (ctrl_reg[CTRL_ENC_BIT] ? RATIO_2 : RATIO_1)))
    else $error("wide bus ratio wrong");
  request_low_a: assert property ($fell(req_s) |-> ##[1:2] (!config_status_n_oe_n && !config_complete))
    else $error("status or completion not pulled low after request");
  status_min_a: assert property ($rose(config_status_n_oe_n) |-> $past(low_cnt_reg) >= STATUS_MIN_CYCLES)
    else $error("status released too early");
  status_max_a: assert property ((state_reg == ST_RESET) |-> rel_cnt_reg <= STATUS_MAX_CYC)
    else $error("status held past request release limit");
  capture_edge_a: assert property (cfg_word_valid |-> ($past(clk_rise) && $past(state_reg) == ST_LOAD))
    else $error("data captured without clock edge");
  osc_init_a: assert property (($rose(user_mode) && !ctrl_reg[CTRL_UCLK_BIT]) |->
    (init_cnt_reg >= INIT_MIN_CYCLES && init_cnt_reg <= INIT_MAX_CYC)) else $error("oscillator init time wrong");
  user_clk_init_a: assert property (($rose(user_mode) && ctrl_reg[CTRL_UCLK_BIT]) |->
    uedge_cnt_reg >= UINIT_CYCLES) else $error("too few user clock edges");
  por_delay_a: assert property ((state_reg == ST_POR ##1 state_reg != ST_POR) |->
    por_cnt_reg >= (por_fast_reg ? POR_FAST_CYCLES : POR_STD_CYCLES)) else $error("power-on delay too short");
  runout_a: assert property ((state_reg == ST_RUNOUT ##1 state_reg == ST_INIT) |->
    $past(phase_inc) == ratio_reg) else $error("run-out edge count wrong");

endmodule // pcl_load_seq
`default_nettype wire

// *** hw/pcl_pkg.sv ***
// ****************************************************************
// constants for the parallel configuration load sequencer
// ****************************************************************
package pcl_pkg;

  // ****************************************************************
  // clock and timing figures
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_FAST_MS = 4;
  localparam int POR_STD_MS = 100;
  localparam int REQ_TO_LOW_NS = 600;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MAX_US = 1506;
  localparam int INIT_MIN_US = 175;
  localparam int INIT_MAX_US = 437;
  localparam int UINIT_EDGES = 8576;
  // least times round up, longest times round down
  localparam int POR_FAST_CYC = (POR_FAST_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_STD_CYC = (POR_STD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_TO_LOW_CYC = REQ_TO_LOW_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_CYC = (STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_MIN_CYC = (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_MAX_CYC = (INIT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int TMR_W = 32;

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LEN = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hC;
  localparam int CTRL_W16_BIT = 0;
  localparam int CTRL_ENC_BIT = 1;
  localparam int CTRL_CMP_BIT = 2;
  localparam int CTRL_UCLK_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] LEN_RESET = 32'h0000_0001;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RATIO_LSB = 4;
  localparam int STAT_DONE_BIT = 8;
  localparam int STAT_USER_BIT = 9;
  localparam int STAT_FAST_BIT = 10;
  localparam int SEL_FAST_BIT = 0;
  localparam logic [2:0] RATIO_1 = 3'h1;
  localparam logic [2:0] RATIO_2 = 3'h2;
  localparam logic [2:0] RATIO_4 = 3'h4;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_RESET = 3'b001,
    ST_RELEASE = 3'b010,
    ST_LOAD = 3'b011,
    ST_RUNOUT = 3'b100,
    ST_INIT = 3'b101,
    ST_USER = 3'b110
  } pcl_state_t;

endpackage

// *** hw/pcl_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-flop synchroniser for pins from outside the clock domain
// ****************************************************************
module pcl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [WIDTH-1:0] async_in, // raw pin level
  output logic [WIDTH-1:0] sync_out // level safe to read
);
  logic [WIDTH-1:0] stage_reg;
  logic [WIDTH-1:0] stage_next;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb begin
    stage_next = srst ? RESET_VAL : async_in;
    sync_next = srst ? RESET_VAL : stage_reg;
  end

  always_ff @(posedge sys_clk) begin
    stage_reg <= stage_next;
    sync_out <= sync_next;
  end
endmodule // pcl_sync
`default_nettype wire

// *** hw/pcl_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// down counter shared by all phase timers
// ****************************************************************
module pcl_timer
  import pcl_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic load, // load a new count
  input wire logic [TMR_W-1:0] load_val, // count to load
  input wire logic en, // decrement enable
  output logic done // count has reached zero
);
  logic [TMR_W-1:0] count_reg;
  logic [TMR_W-1:0] count_next;

  // load wins over the decrement so a restart is never missed
  always_comb begin
    count_next = count_reg;
    if (srst) begin
      count_next = '0;
    end else if (load) begin
      count_next = load_val;
    end else if (en && count_reg != '0) begin
      count_next = count_reg - TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    count_reg <= count_next;
  end

  assign done = (count_reg == '0);
endmodule // pcl_timer
`default_nettype wire

// *** test/pcl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host controller model driving the configuration pins
// ****************************************************************
module pcl_host_model
  import pcl_pkg::*;
(
  input wire logic sys_clk, // bench clock, paces every pin change
  input wire logic config_status_n, // status wire level
  input wire logic config_complete, // completion line
  output logic config_request_n, // request pin
  output logic config_clock, // configuration clock, parked low
  output logic [15:0] config_data, // data pins
  output logic user_init_clock // initialization clock, parked low
);
  localparam int HOLD_CYC = 2000 / CLK_PERIOD_NS; // 2 us

  // idle pins: request released, both clocks still between frames
  initial begin
    config_request_n = 1'b1;
    config_clock = 1'b0;
    config_data = 16'h0;
    user_init_clock = 1'b0;
  end

  // 48 ns period with equal phases, well inside the 125 MHz ceiling
  task automatic clocks(input int n);
    repeat (n) begin
      repeat (6) @(posedge sys_clk);
      config_clock <= 1'b1;
      repeat (6) @(posedge sys_clk);
      config_clock <= 1'b0;
    end
  endtask

  // an item is held across all r periods of its slot
  task automatic send_item(input logic [15:0] d, input int r);
    @(posedge sys_clk);
    config_data <= d;
    clocks(r);
  endtask

  // bus let go after the frame: show the inverse, never a stale value
  task automatic park();
    @(posedge sys_clk);
    config_data <= ~config_data;
  endtask

  // pulse request low, time the device's answer and its status low phase
  task automatic restart(output int lat, output int low);
    time t0;
    time t1;
    @(posedge sys_clk);
    config_request_n <= 1'b0;
    t0 = $time;
    t1 = t0;
    lat = 9999;
    repeat (HOLD_CYC) begin
      @(posedge sys_clk);
      #1;
      if (lat == 9999 && config_status_n === 1'b0 && config_complete === 1'b0) begin
        lat = int'(($time - t0) / CLK_PERIOD_NS);
        t1 = $time;
      end
    end
    @(posedge sys_clk);
    config_request_n <= 1'b1;
    for (int i = 0; i < 4000 && config_status_n !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    low = int'(($time - t1) / CLK_PERIOD_NS);
    repeat (HOLD_CYC) @(posedge sys_clk);
  endtask

  // init clock starts only after a lead-in, then gives n rising edges
  task automatic user_clock(input int lead, input int n);
    repeat (lead) @(posedge sys_clk);
    repeat (n) begin
      repeat (6) @(posedge sys_clk);
      user_init_clock <= 1'b1;
      repeat (6) @(posedge sys_clk);
      user_init_clock <= 1'b0;
    end
  endtask
endmodule // pcl_host_model
`default_nettype wire

// *** test/pcl_load_seq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bench for the parallel configuration load sequencer
// ****************************************************************
module pcl_load_seq_tb
  import pcl_pkg::*;
;
  localparam int POR_F = 100;
  localparam int POR_S = 200;
  localparam int STAT_MIN = 800; // above the 2 us request pulse, so the timer decides
  localparam int INIT_MIN = 40;
  localparam int UINIT = 20;
  localparam int TIMEOUT_CYC = 60000;
  logic sys_clk = 1'b0;
  logic srst, reg_wr, reg_rd, rd_d, config_request_n, config_clock, user_init_clock;
  logic status_n_out, status_oe_n, config_complete, user_mode, cfg_word_valid;
  logic [1:0] scheme_select_pins;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lfsr_q;
  logic [15:0] cfg_word, config_data;
  logic [31:0] wq[$];
  logic [63:0] rq[$];
  int bad_count, compares, cyc;
  time t_cd;
  wire logic status_wire;

  // open-drain status wire with pull-up
  assign status_wire = status_oe_n ? 1'b1 : status_n_out;

  pcl_load_seq #(.POR_FAST_CYCLES(POR_F), .POR_STD_CYCLES(POR_S), .STATUS_MIN_CYCLES(STAT_MIN),
    .INIT_MIN_CYCLES(INIT_MIN), .UINIT_CYCLES(UINIT)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .config_request_n(config_request_n), .config_clock(config_clock), .config_data(config_data),
    .scheme_select_pins(scheme_select_pins), .user_init_clock(user_init_clock),
    .config_status_n_in(status_wire), .config_status_n_out(status_n_out), .config_status_n_oe_n(status_oe_n),
    .config_complete(config_complete), .user_mode(user_mode), .cfg_word(cfg_word),
    .cfg_word_valid(cfg_word_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  pcl_host_model host_u (.sys_clk(sys_clk), .config_status_n(status_wire), .config_complete(config_complete),
    .config_request_n(config_request_n), .config_clock(config_clock), .config_data(config_data),
    .user_init_clock(user_init_clock));

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("TB: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [2:0] exp_ratio(input logic [3:0] c);
    if (c[CTRL_CMP_BIT]) return c[CTRL_W16_BIT] ? RATIO_4 : RATIO_2;
    return (c[CTRL_W16_BIT] && c[CTRL_ENC_BIT]) ? RATIO_2 : RATIO_1;
  endfunction

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // the expectation is queued with its mask; the monitor compares later
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back({m, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin : rd_mon
    logic [63:0] e;
    if (rd_d === 1'b1) begin
      if (rq.size() == 0) check(32'h1, 32'h0);
      else begin
        e = rq.pop_front();
        check(reg_rdata & e[63:32], e[31:0]);
      end
    end
    rd_d <= reg_rd;
  end

  // each capture strobe takes the oldest item sent; unused upper byte must read zero
  always @(posedge sys_clk) begin : word_mon
    logic [31:0] e;
    if (cfg_word_valid === 1'b1) begin
      if (wq.size() == 0) check(32'h1, 32'h0);
      else begin
        e = wq.pop_front();
        check({16'h0, cfg_word}, {16'h0, e[15:0]});
      end
    end
  end

  // init time is reckoned from the completion line rising, not from the bench's own pace
  always @(posedge config_complete) t_cd = $time;

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC) begin
      bad_count++;
      $display("ERROR %0t ns: timeout", $time);
      stop_test();
    end
  end

  task automatic por_check(input logic [1:0] pins, input int lo);
    time t0;
    int t;
    scheme_select_pins <= pins;
    srst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t0 = $time;
    @(posedge sys_clk);
    #1;
    check({31'h0, status_wire}, 32'h0);
    while (status_wire !== 1'b1 && ($time - t0) < 8000) begin
      @(posedge sys_clk);
      #1;
    end
    t = int'(($time - t0) / CLK_PERIOD_NS);
    check(32'(t >= lo && t <= lo + 40), 32'h1);
    reg_read(REG_STAT, pins[SEL_FAST_BIT] ? 32'h400 : 32'h0, 32'h400);
    reg_read(REG_CTRL, 32'h0, 32'hF);
    reg_read(REG_LEN, LEN_RESET, 32'hFFFF_FFFF);
    $display("TB: power-on pins=%b done", pins);
  endtask

  // one full load; cut > 0 stops after that many items, as an abort
  task automatic do_load(input logic [3:0] ctrl, input int n, input int cut);
    logic [2:0] r;
    logic [15:0] m;
    int lat, low, t;
    r = exp_ratio(ctrl);
    m = ctrl[CTRL_W16_BIT] ? 16'hFFFF : 16'h00FF;
    reg_write(REG_CTRL, {28'h0, ctrl});
    reg_write(REG_LEN, 32'(n));
    host_u.restart(lat, low);
    check(32'(lat <= REQ_TO_LOW_CYC), 32'h1);
    check(32'(low >= STAT_MIN && low <= STAT_MIN + 32), 32'h1);
    reg_read(REG_STAT, {25'h0, r, 1'b0, ST_LOAD}, 32'h377);
    for (int i = 0; i < n; i++) begin
      if (i == cut && cut != 0) return;
      lfsr_q = lfsr_step(lfsr_q);
      wq.push_back({m, lfsr_q[15:0] & m});
      // the last item gets only its capture edge; its r-1 run-out edges follow below
      host_u.send_item(lfsr_q[15:0], (i == n - 1) ? 1 : int'(r));
    end
    if (r > 3'h1) begin
      host_u.clocks(int'(r) - 2);
      check({31'h0, config_complete}, 32'h0);
      host_u.clocks(1);
    end
    host_u.park();
    t = 0;
    while (config_complete !== 1'b1 && t < 40) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    check({31'h0, config_complete}, 32'h1);
    t = 0;
    if (ctrl[CTRL_UCLK_BIT]) begin
      host_u.user_clock(48, UINIT - 1);
      repeat (10) @(posedge sys_clk);
      check({31'h0, user_mode}, 32'h0);
      host_u.user_clock(0, 1);
      repeat (10) @(posedge sys_clk);
      check({31'h0, user_mode}, 32'h1);
    end else begin
      while (user_mode !== 1'b1 && t < 400) begin
        @(posedge sys_clk);
        #1;
        t++;
      end
      t = int'(($time - t_cd) / CLK_PERIOD_NS);
      check(32'(t >= INIT_MIN - 1 && t <= INIT_MIN + 16), 32'h1);
    end
    reg_read(REG_COUNT, 32'(n), 32'hFFFF_FFFF);
    reg_read(REG_STAT, {22'h0, 2'b11, 5'h0, ST_USER}, 32'h307);
    check(32'(wq.size()), 32'h0);
    $display("TB: load ctrl=%h items=%0d done", ctrl, n);
  endtask

  // main sequence: power-on, every ratio mode, registers, abort, init clock, standard power-on
  initial begin
    srst = 1'b1;
    scheme_select_pins = 2'b01;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    lfsr_q = 32'h978C;
    bad_count = 0;
    compares = 0;
    cyc = 0;
    por_check(2'b01, POR_F + STAT_MIN);
    for (int k = 0; k < 8; k++) begin
      lfsr_q = lfsr_step(lfsr_q);
      do_load(4'(k), 1 + int'(lfsr_q[1:0]), 0);
    end
    reg_write(REG_CTRL, 32'hF);
    reg_read(REG_CTRL, 32'hF, 32'hF);
    reg_write(4'h2, 32'hFFFF_FFFF);
    reg_read(4'h2, 32'h0, 32'hFFFF_FFFF);
    reg_write(REG_STAT, 32'h0);
    reg_read(REG_STAT, {22'h0, 2'b11, 5'h0, ST_USER}, 32'h307);
    $display("TB: register access done");
    do_load(4'h5, 3, 1);
    do_load(4'h5, 3, 0);
    do_load(4'hD, 2, 0);
    por_check(2'b00, POR_S + STAT_MIN);
    do_load(4'h0, 1, 0);
    stop_test();
  end
endmodule // pcl_load_seq_tb
`default_nettype wire
